// ===== core/mdsu_consts.vh
// Constants of the multiply, divide and shift unit
`ifndef MDSU_CONSTS_VH
`define MDSU_CONSTS_VH

// Register addresses on the special function register port
`define MDSU_A_B0 3'h0
`define MDSU_A_B1 3'h1
`define MDSU_A_B2 3'h2
`define MDSU_A_B3 3'h3
`define MDSU_A_B4 3'h4
`define MDSU_A_B5 3'h5
`define MDSU_A_CTL 3'h6

// Control register fields
`define MDSU_CTL_CNT 4:0
`define MDSU_CTL_DIR 5
`define MDSU_CTL_NORM 6
`define MDSU_CTL_DZ 7
`define MDSU_CTL_RESET 8'h00

// Timing: clocks per machine cycle and shift speed limit
`define MDSU_MC_CLKS 12
`define MDSU_SHIFTS_PER_MC 6
`define MDSU_SHIFT_CLKS (`MDSU_MC_CLKS / `MDSU_SHIFTS_PER_MC)

// Iteration counts
`define MDSU_DIV32_STEPS 6'h20
`define MDSU_HALF_STEPS 6'h10
`define MDSU_NORM_STEPS 6'h1f

`endif

// ===== core/mdsu_div_step.v
// One restoring division step for the multiply, divide and shift unit
`timescale 1ns/10ps
`default_nettype none

module mdsu_div_step (
  input wire [15:0] rem_in,
  input wire bit_in,
  input wire [15:0] divisor,
  output wire [15:0] rem_out,
  output wire q_bit
);

  wire [16:0] trial;
  wire [17:0] diff;

  assign trial = {rem_in, bit_in};
  assign diff = {1'b0, trial} - {2'b00, divisor};
  // Unsigned compare: no borrow means trial >= divisor
  assign q_bit = ~diff[17]; // RULE2
  assign rem_out = q_bit ? diff[15:0] : trial[15:0];

endmodule // mdsu_div_step

`default_nettype wire

// ===== core/mdsu_mul_div_unit.v
// Multiply, divide, shift and normalize unit behind byte-wide registers
//
// Function
// RULE1: The unit does 32/16 and 16/16 division, 16x16 multiply, 32-bit normalize and shifts.
// RULE2: All operands and results are unsigned.
// RULE3: A 32/16 division gives a 32-bit quotient and 16-bit remainder within 6 machine cycles.
// RULE4: 16/16 division and 16x16 multiply finish within 4 machine cycles of 12 clocks.
// RULE5: Shift and normalize finish within 6 machine cycles, at most 6 shifts per cycle.
// RULE6: There are six byte registers for operands and results and one control register.
// RULE7: The order of the operand writes selects the operation, with no opcode field.
// RULE8: For 32/16 division the core writes bytes 0 to 3, then byte 4, then byte 5 last.
// RULE9: For 16/16 division the core writes bytes 0, 1, 4 and finally 5.
// RULE10: Multiply is written as 0, 4, 1, 5 and the product returns in bytes 0 to 3.
// RULE11: Quotient returns in bytes 0 up, remainder in bytes 4 and 5, read 0 first, 5 last.
// RULE12: Shift operand goes to bytes 0 to 3, the control write starts it, result in 0 to 3.
// RULE13: The low byte is the least significant and the high byte the most significant.
// RULE14: The control register holds shift count, direction and normalize select.
`timescale 1ns/10ps
`default_nettype none
`include "mdsu_consts.vh"

module mdsu_mul_div_unit (
  input wire clk,
  input wire rst,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [2:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output wire [7:0] sfr_rdata,
  output wire busy,
  output wire done
);
  // ***************************************************************
  // States
  // ***************************************************************
  localparam [8:0] SQ_IDLE = 9'h001;
  localparam [8:0] SQ_W0 = 9'h002;
  localparam [8:0] SQ_W01 = 9'h004;
  localparam [8:0] SQ_W012 = 9'h008;
  localparam [8:0] SQ_W0123 = 9'h010;
  localparam [8:0] SQ_W01234 = 9'h020;
  localparam [8:0] SQ_W014 = 9'h040;
  localparam [8:0] SQ_W04 = 9'h080;
  localparam [8:0] SQ_W041 = 9'h100;
  localparam [3:0] EX_IDLE = 4'h1;
  localparam [3:0] EX_DIV = 4'h2;
  localparam [3:0] EX_MUL = 4'h4;
  localparam [3:0] EX_SHF = 4'h8;
  localparam integer SHF_LAST = `MDSU_SHIFT_CLKS - 1;

  // ***************************************************************
  // Storage
  // ***************************************************************
  reg [31:0] acc_reg;
  reg [15:0] aux_reg;
  reg [15:0] wrk_reg;
  reg [7:0] ctl_reg;
  reg [5:0] left_reg;
  reg [3:0] ph_reg;
  reg [8:0] seq_reg;
  reg [3:0] ex_reg;
  reg [7:0] rdata_reg;
  reg busy_reg;
  reg done_reg;
  wire [15:0] step_rem;
  wire step_q;
  wire [16:0] mul_sum;
  assign sfr_rdata = rdata_reg;
  assign busy = busy_reg;
  assign done = done_reg;

  // ***************************************************************
  // Decoding
  // ***************************************************************
  // Track the order of operand writes
  function [8:0] next_seq;
    input [8:0] s;
    input [2:0] a;
    begin
      next_seq = SQ_IDLE;
      case (a)
        `MDSU_A_B0: next_seq = SQ_W0;
        `MDSU_A_B1:
          if (s == SQ_W0)
            next_seq = SQ_W01;
          else if (s == SQ_W04)
            next_seq = SQ_W041;
        `MDSU_A_B2:
          if (s == SQ_W01)
            next_seq = SQ_W012;
        `MDSU_A_B3:
          if (s == SQ_W012)
            next_seq = SQ_W0123;
        `MDSU_A_B4:
          if (s == SQ_W0123)
            next_seq = SQ_W01234;
          else if (s == SQ_W01)
            next_seq = SQ_W014;
          else if (s == SQ_W0)
            next_seq = SQ_W04;
        default: next_seq = SQ_IDLE;
      endcase
    end
  endfunction
  // Read multiplexer
  function [7:0] rd_byte;
    input [2:0] a;
    input [31:0] acc;
    input [15:0] aux;
    input [7:0] ctl;
    begin
      case (a)
        `MDSU_A_B0: rd_byte = acc[7:0];
        `MDSU_A_B1: rd_byte = acc[15:8];
        `MDSU_A_B2: rd_byte = acc[23:16];
        `MDSU_A_B3: rd_byte = acc[31:24];
        `MDSU_A_B4: rd_byte = aux[7:0];
        `MDSU_A_B5: rd_byte = aux[15:8];
        `MDSU_A_CTL: rd_byte = ctl; // RULE6
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction
  // ***************************************************************
  // Datapath helpers
  // ***************************************************************
  mdsu_div_step u_step (
    .rem_in(wrk_reg),
    .bit_in(acc_reg[31]),
    .divisor(aux_reg),
    .rem_out(step_rem),
    .q_bit(step_q)
  );
  // Shift-add partial product, multiplicand held in wrk_reg
  assign mul_sum = {1'b0, acc_reg[31:16]} + (acc_reg[0] ? {1'b0, wrk_reg} : 17'h00000); // RULE2
  // ***************************************************************
  // Control and datapath
  // ***************************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      acc_reg <= 32'h00000000;
      aux_reg <= 16'h0000;
      wrk_reg <= 16'h0000;
      ctl_reg <= `MDSU_CTL_RESET;
      left_reg <= 6'h00;
      ph_reg <= 4'h0;
      seq_reg <= SQ_IDLE;
      ex_reg <= EX_IDLE;
      rdata_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (sfr_rd)
        rdata_reg <= rd_byte(sfr_addr, acc_reg, aux_reg, ctl_reg); // RULE11
      case (ex_reg) // RULE1
        EX_IDLE:
          if (sfr_wr)
          begin
            seq_reg <= next_seq(seq_reg, sfr_addr); // RULE7
            case (sfr_addr)
              `MDSU_A_B0: acc_reg[7:0] <= sfr_wdata; // RULE13
              `MDSU_A_B1: acc_reg[15:8] <= sfr_wdata;
              `MDSU_A_B2: acc_reg[23:16] <= sfr_wdata;
              `MDSU_A_B3: acc_reg[31:24] <= sfr_wdata;
              `MDSU_A_B4: aux_reg[7:0] <= sfr_wdata;
              `MDSU_A_B5:
              begin
                aux_reg[15:8] <= sfr_wdata;
                if (seq_reg == SQ_W01234)
                begin
                  // 32/16 division: dividend in bytes 0..3
                  wrk_reg <= 16'h0000; // RULE8
                  left_reg <= `MDSU_DIV32_STEPS;
                  ex_reg <= EX_DIV;
                  busy_reg <= 1'b1;
                  ctl_reg[`MDSU_CTL_DZ] <= ({sfr_wdata, aux_reg[7:0]} == 16'h0000);
                end
                else if (seq_reg == SQ_W014)
                begin
                  // 16/16 division: move dividend to the top half
                  acc_reg <= {acc_reg[15:0], 16'h0000}; // RULE9
                  wrk_reg <= 16'h0000;
                  left_reg <= `MDSU_HALF_STEPS;
                  ex_reg <= EX_DIV;
                  busy_reg <= 1'b1;
                  ctl_reg[`MDSU_CTL_DZ] <= ({sfr_wdata, aux_reg[7:0]} == 16'h0000);
                end
                else if (seq_reg == SQ_W041)
                begin
                  // Multiply: multiplier to the low half, multiplicand aside
                  wrk_reg <= acc_reg[15:0]; // RULE10
                  acc_reg <= {16'h0000, sfr_wdata, aux_reg[7:0]};
                  left_reg <= `MDSU_HALF_STEPS;
                  ex_reg <= EX_MUL;
                  busy_reg <= 1'b1;
                end
              end
              `MDSU_A_CTL:
              begin
                ctl_reg[6:0] <= sfr_wdata[6:0]; // RULE14
                ph_reg <= 4'h0;
                if (sfr_wdata[`MDSU_CTL_NORM])
                begin
                  ctl_reg[`MDSU_CTL_CNT] <= 5'h00;
                  left_reg <= `MDSU_NORM_STEPS;
                  ex_reg <= EX_SHF; // RULE12
                  busy_reg <= 1'b1;
                end
                else if (sfr_wdata[`MDSU_CTL_CNT] != 5'h00)
                begin
                  left_reg <= {1'b0, sfr_wdata[`MDSU_CTL_CNT]};
                  ex_reg <= EX_SHF; // RULE12
                  busy_reg <= 1'b1;
                end
                else
                  done_reg <= 1'b1;
              end
              default: seq_reg <= SQ_IDLE;
            endcase
          end
        EX_DIV:
        begin
          // One quotient bit per clock, quotient collects in acc_reg
          acc_reg <= {acc_reg[30:0], step_q}; // RULE3 RULE4
          wrk_reg <= step_rem;
          left_reg <= left_reg - 6'h01;
          if (left_reg == 6'h01)
          begin
            aux_reg <= step_rem; // RULE11
            ex_reg <= EX_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
        EX_MUL:
        begin
          acc_reg <= {mul_sum, acc_reg[15:1]}; // RULE4 RULE10
          left_reg <= left_reg - 6'h01;
          if (left_reg == 6'h01)
          begin
            ex_reg <= EX_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
        EX_SHF:
        begin
          // One position every SHIFT_CLKS clocks keeps within the speed limit
          if (ph_reg == SHF_LAST[3:0])
          begin
            ph_reg <= 4'h0; // RULE5
            if (ctl_reg[`MDSU_CTL_NORM])
            begin
              if (acc_reg[31] || (acc_reg == 32'h00000000) || (left_reg == 6'h00))
              begin
                ex_reg <= EX_IDLE;
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
              end
              else
              begin
                acc_reg <= {acc_reg[30:0], 1'b0};
                ctl_reg[`MDSU_CTL_CNT] <= ctl_reg[`MDSU_CTL_CNT] + 5'h01;
                left_reg <= left_reg - 6'h01;
              end
            end
            else
            begin
              if (ctl_reg[`MDSU_CTL_DIR])
                acc_reg <= {1'b0, acc_reg[31:1]};
              else
                acc_reg <= {acc_reg[30:0], 1'b0};
              left_reg <= left_reg - 6'h01;
              if (left_reg == 6'h01)
              begin
                ex_reg <= EX_IDLE;
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
              end
            end
          end
          else
            ph_reg <= ph_reg + 4'h1;
        end
        default:
        begin
          ex_reg <= EX_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule // mdsu_mul_div_unit
`default_nettype wire

// ===== test/mdsu_checker_assertions.sv
// Port timing checker of the multiply, divide and shift unit
`timescale 1ns/10ps
`default_nettype none
module mdsu_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [2:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic busy,
  input wire logic done
);
  logic [6:0] sh_reg;
  wire go = sfr_wr && !busy && sfr_addr == 3'h6 && !sfr_wdata[6];
  // Done is due two clocks per position, seen one clock after it is set
  always @(posedge clk)
  begin
    if (rst)
      sh_reg <= 7'h0;
    else if (go)
      sh_reg <= {1'b0, sfr_wdata[4:0], 1'b1};
    else if (sh_reg != 7'h0)
      sh_reg <= sh_reg - 7'h1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  done_pulse_a: assert property (done |=> !done) else $error("done too long");
  done_idle_a: assert property (done |-> !busy) else $error("busy at done");
  busy_end_a: assert property ($fell(busy) && !$past(rst) |-> done) else $error("no done");
  op_bound_a: assert property ($rose(busy) |-> ##[1:71] done) else $error("op too slow");
  reset_idle_a: assert property ($fell(rst) |-> !busy && !done && sfr_rdata == 8'h00)
    else $error("reset state");
  rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("rdata moved");
  unmapped_a: assert property (sfr_rd && sfr_addr == 3'h7 |=> sfr_rdata == 8'h00)
    else $error("unmapped read");
  shift_go_a: assert property (go && sfr_wdata[4:0] != 5'h0 |=> busy) else $error("no start");
  shift_time_a: assert property (sh_reg != 7'h0 |-> done == (sh_reg == 7'h1))
    else $error("shift time");
  zero_shift_a: assert property (go && sfr_wdata[4:0] == 5'h0 |=> done && !busy)
    else $error("zero shift");
endmodule // mdsu_checker
`default_nettype wire

// ===== test/mdsu_core_model.sv
// Core model: writes operands and reads results of the unit
`timescale 1ns/10ps
`default_nettype none
module mdsu_core_model (
  input wire logic clk,
  output logic sfr_wr = 1'b0,
  output logic sfr_rd = 1'b0,
  output logic [2:0] sfr_addr = 3'h7,
  output logic [7:0] sfr_wdata = 8'h00,
  input wire logic [7:0] sfr_rdata
);
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_wdata = ~d;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge clk);
    #1;
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  // Write order picks the operation
  task load(input int k, input logic [31:0] x, input logic [15:0] y, input logic [7:0] c);
    wr(3'h0, x[7:0]);
    if (k == 2)
      wr(3'h4, y[7:0]);
    wr(3'h1, x[15:8]);
    if (k == 0 || k == 3)
      wr(3'h2, x[23:16]);
    if (k == 0 || k == 3)
      wr(3'h3, x[31:24]);
    if (k < 2)
      wr(3'h4, y[7:0]);
    if (k == 3)
      wr(3'h6, c);
    else
      wr(3'h5, y[15:8]);
  endtask
  task rdall(input int n, output logic [47:0] v);
    v = 48'h0;
    for (int i = 0; i < n; i++)
      rd(i[2:0], v[8*i+:8]);
  endtask
endmodule // mdsu_core_model
`default_nettype wire

// ===== test/testbench.sv
// Random and corner tests of the unit through the core model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire sfr_wr;
  wire sfr_rd;
  wire busy;
  wire done;
  wire [2:0] sfr_addr;
  wire [7:0] sfr_wdata;
  wire [7:0] sfr_rdata;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h00016159;
  logic [7:0] b;
  mdsu_mul_div_unit i_mdsu_mul_div_unit (.clk(clk), .rst(rst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .busy(busy), .done(done));
  mdsu_core_model i_mdsu_core_model (.clk(clk), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  initial
  begin
    forever
      #25 clk = ~clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [47:0] g, input logic [47:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task op(input int k, input logic [31:0] x, input logic [15:0] y, input logic [7:0] c);
    logic [47:0] e;
    logic [47:0] g;
    logic [31:0] q;
    logic [31:0] r;
    int s;
    int t;
    s = 0;
    t = 0;
    r = {16'h0, y};
    q = x[15:0] * y;
    if (k < 2)
      x = k == 1 ? {16'h0, x[15:0]} : x;
    if (k < 2)
      q = y == 16'h0 ? 32'hffffffff >> (16 * k) : x / y;
    if (k < 2)
      r = x % y;
    if (k == 3)
      q = c[6] ? x : c[5] ? x >> c[4:0] : x << c[4:0];
    while (k == 3 && c[6] && q != 32'h0 && !q[31])
    begin
      q = q << 1;
      s++;
    end
    i_mdsu_core_model.load(k, x, y, c);
    // A write while busy must leave the product alone
    if (k == 2 && x[16])
      i_mdsu_core_model.wr(3'h0, 8'h5a);
    while (done !== 1'b1 && t < 100)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    if (t == 100)
    begin
      n_mismatch++;
      $display("mismatch %0t no done for op %0d", $time, k);
      end_of_test;
    end
    chk(48'(t > (k % 3 ? 48 : 72)), 48'h0);
    i_mdsu_core_model.rdall(k == 3 ? 4 : 6, g);
    e = {k == 3 ? 16'h0 : r[15:0], q};
    if (k < 2 && y == 16'h0)
      e[47:32] = g[47:32];
    chk(g, e);
    i_mdsu_core_model.rd(3'h6, b);
    if (k < 2)
      chk(48'(b[7]), 48'(y == 16'h0));
    if (k == 3 && c[6])
      chk(48'({b[6], b[4:0]}), 48'({1'b1, s[4:0]}));
    if (k == 3 && !c[6])
      chk(48'(b[6:0]), 48'(c[6:0]));
    $display("op %0d on %h ends", k, x);
  endtask
  initial
  begin
    repeat (2)
      @(posedge clk);
    #1;
    rst = 1'b0;
    for (int a = 0; a < 8; a++)
    begin
      i_mdsu_core_model.rd(a[2:0], b);
      chk(48'(b), 48'h0);
    end
    $display("reset read test ends");
    // A lone last byte must not start anything
    i_mdsu_core_model.wr(3'h5, 8'h01);
    b = 8'h0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      b = b | {7'h0, busy};
    end
    chk(48'(b), 48'h0);
    $display("lone byte test ends");
    op(0, 32'hffffffff, 16'h0001, 8'h00);
    op(1, 32'h0000abcd, 16'h0000, 8'h00);
    op(2, 32'h0001ffff, 16'hffff, 8'h00);
    op(3, 32'h80000001, 16'h0000, 8'h3f);
    op(3, 32'h00000001, 16'h0000, 8'h40);
    op(3, 32'h00000000, 16'h0000, 8'h40);
    op(3, 32'h12345678, 16'h0000, 8'h00);
    repeat (40)
      op(int'(rnd() & 32'h3), rnd(), 16'(rnd()), 8'(rnd()));
    end_of_test;
  end
endmodule // testbench
bind mdsu_mul_div_unit mdsu_checker i_mdsu_checker (.clk(clk), .rst(rst), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .busy(busy), .done(done));
`default_nettype wire
